// ---- design/brsdvs_top.sv ----
// Contract
// - One shared bit picks voltage-and-current or current-only power-good.
// - Combined mode: good only while unmasked rails in window, under limit.
// - Every source maskable in two registers; reset leaves dual rail a only.
// - Voltage check of a ramping rail is suppressed.
// - Combine bit adds power-good to current result; one rail measured.
// - External converter good pin is an extra power-good source.
// - Scaling rails move their target at a fixed 2.5 mV/us.
// - Pin control: assigned pin active picks primary, else alternate; unassigned rail stays primary.
// - Alternate code zero turns the rail off when selected.
// - Alternate-select bit defaults primary, works only with pin control off.
// - Non-scaling rails jump straight to a new target.
// - Strap picks dual or triple for group a; dual registers drive triple.
// - Same strap choice for group b, dual registers drive triple.
// - Multi-phase rails auto-shed phases; two-bit field forces either mode.
// - Dual phases opposite, triple 120 deg apart, one phase at light load.
// - LDO range crossing is refused unless the regulator restarts.
// - Analog supply LDO follows analog demand automatically.
// - Primary code zero also turns the rail off.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
module brsdvs_top #(
  parameter int STEP_CYC = brsdvs_pkg::DVS_STEP_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [6:0] I_RAIL_VOK,
  input wire logic [6:0] I_RAIL_ILIM,
  input wire logic I_EXT_PG,
  input wire logic I_SLEEP_CTRL_PIN_N,
  input wire logic I_AUX_ENABLE_PIN,
  input wire logic I_LIGHT_LOAD_A,
  input wire logic I_LIGHT_LOAD_B,
  input wire logic I_OTP_TRIPLE_A,
  input wire logic I_OTP_TRIPLE_B,
  input wire logic [3:0] I_ANA_REQ,
  output logic O_POWER_GOOD,
  output logic [55:0] O_RAIL_CODE,
  output logic [6:0] O_RAIL_EN,
  output logic [6:0] O_ADC_ILMON_SEL,
  output logic O_ADC_PG_TAG,
  output logic [1:0] O_PHASES_A,
  output logic [1:0] O_PHASES_B,
  output logic O_STAGGER_120_A,
  output logic O_STAGGER_120_B,
  output logic O_LDO_EN,
  output logic [5:0] O_LDO_CODE,
  output logic O_ANA_LDO_EN
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] mask_a;
    logic [3:0] mask_b;
    logic [7:0] ctrl;
    logic [7:0] pin_map;
    logic [6:0][7:0] prim;
    logic [3:0][8:0] alt;
    logic [3:0] adc_sel;
    logic [6:0] ldo;
    logic otp_done;
    logic triple_a;
    logic triple_b;
    logic pg_out;
    logic pg_tag;
    logic [6:0] ilmon;
    logic [6:0][7:0] rail_code;
    logic [6:0] rail_en;
    logic [1:0] phases_a;
    logic [1:0] phases_b;
    logic ana_en;
  } brsdvs_st_t;

  brsdvs_st_t st_ff;
  brsdvs_st_t nxt_st;

  logic [brsdvs_pkg::NUM_SYNC-1:0] sync_in;
  logic [brsdvs_pkg::NUM_SYNC-1:0] sync_out;
  logic [6:0] vok;
  logic [6:0] ilim;
  logic ext_pg;
  logic sleep_act;
  logic aux_act;
  logic light_a;
  logic light_b;
  logic otp_a;
  logic otp_b;
  logic [3:0] ana_req;
  logic [3:0][7:0] dvs_target;
  logic [3:0][7:0] dvs_code;
  logic [3:0] dvs_ramp;
  logic [6:0] ramping;
  logic [6:0][7:0] code_now;
  logic [6:0] fault;
  logic [6:0] src_used;
  logic pg_ok;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  assign sync_in = {I_ANA_REQ, I_OTP_TRIPLE_B, I_OTP_TRIPLE_A,
    I_LIGHT_LOAD_B, I_LIGHT_LOAD_A, I_AUX_ENABLE_PIN, I_SLEEP_CTRL_PIN_N,
    I_EXT_PG, I_RAIL_ILIM, I_RAIL_VOK};

  brsdvs_sync #(
    .WIDTH(brsdvs_pkg::NUM_SYNC)
  ) u_sync (
    .I_MCLK(I_MCLK),
    .I_RST_N(I_RST_N),
    .i_ce(I_CE),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign vok = sync_out[6:0];
  assign ilim = sync_out[13:7];
  assign ext_pg = sync_out[14];
  assign sleep_act = sync_out[15];
  assign aux_act = sync_out[16];
  assign light_a = sync_out[17];
  assign light_b = sync_out[18];
  assign otp_a = sync_out[19];
  assign otp_b = sync_out[20];
  assign ana_req = sync_out[24:21];

  // ----------------------------------------------------------------------
  // Level selection and slew for the scaling rails
  // ----------------------------------------------------------------------
  localparam int DVS_SLOT [4] = '{brsdvs_pkg::RAIL_A, brsdvs_pkg::RAIL_B,
    brsdvs_pkg::RAIL_D, brsdvs_pkg::RAIL_F};

  for (genvar g = 0; g < brsdvs_pkg::NUM_DVS; g++) begin : g_dvs
    logic pin_on;
    logic assigned;
    logic use_alt;
    assign assigned = st_ff.pin_map[g] | st_ff.pin_map[g+4];
    assign pin_on = (st_ff.pin_map[g] & sleep_act)
      | (st_ff.pin_map[g+4] & aux_act);
    // Unassigned rail under pin control falls back to the primary level
    assign use_alt = st_ff.ctrl[g+4] ? (assigned & ~pin_on)
      : st_ff.alt[g][brsdvs_pkg::ALT_SEL_BIT];
    assign dvs_target[g] = use_alt ? st_ff.alt[g][7:0]
      : st_ff.prim[DVS_SLOT[g]];

    brsdvs_slew #(
      .CODE_W(8),
      .STEP_CYC(STEP_CYC)
    ) u_slew (
      .I_MCLK(I_MCLK),
      .I_RST_N(I_RST_N),
      .i_ce(I_CE),
      .i_target(dvs_target[g]),
      .o_code(dvs_code[g]),
      .o_ramping(dvs_ramp[g])
    );
  end

  always_comb begin
    code_now = st_ff.prim;
    ramping = '0;
    for (int i = 0; i < brsdvs_pkg::NUM_DVS; i++) begin
      code_now[DVS_SLOT[i]] = dvs_code[i];
      ramping[DVS_SLOT[i]] = dvs_ramp[i];
    end
    // Triple mode folds the single rail into the dual rail's registers
    if (st_ff.triple_a) begin
      code_now[brsdvs_pkg::RAIL_C] = '0;
    end
    if (st_ff.triple_b) begin
      code_now[brsdvs_pkg::RAIL_E] = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Power-good combine
  // ----------------------------------------------------------------------
  always_comb begin
    src_used = ~st_ff.mask_a;
    src_used[brsdvs_pkg::RAIL_C] = src_used[brsdvs_pkg::RAIL_C]
      & ~st_ff.triple_a;
    src_used[brsdvs_pkg::RAIL_E] = src_used[brsdvs_pkg::RAIL_E]
      & ~st_ff.triple_b;
    for (int i = 0; i < brsdvs_pkg::NUM_RAILS; i++) begin
      fault[i] = ilim[i]
        | (~st_ff.mask_b[brsdvs_pkg::MB_TYPE_SEL]
        & ~ramping[i] & ~vok[i]);
    end
  end

  assign pg_ok = ~|(fault & src_used)
    & (ext_pg | st_ff.mask_b[brsdvs_pkg::MB_EXT_MASK]);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [5:0] ph_idx;
  logic wr_go;
  logic [5:0] new_ldo_code;
  logic new_ldo_en;

  always_comb begin
    nxt_st = st_ff;
    ph_idx = '0;
    wr_go = 1'b0;
    new_ldo_code = '0;
    new_ldo_en = 1'b0;
    if (I_CE) begin
      // Write address and data may arrive in either order
      if (I_AWVALID && st_ff.awready) begin
        nxt_st.aw_have = 1'b1;
        nxt_st.awaddr = I_AWADDR;
        nxt_st.awready = 1'b0;
      end
      if (I_WVALID && st_ff.wready) begin
        nxt_st.w_have = 1'b1;
        nxt_st.wdata = I_WDATA;
        nxt_st.wstrb = I_WSTRB;
        nxt_st.wready = 1'b0;
      end
      wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
      if (st_ff.bvalid && I_BREADY) begin
        nxt_st.bvalid = 1'b0;
        nxt_st.awready = 1'b1;
        nxt_st.wready = 1'b1;
      end
      if (wr_go) begin
        nxt_st.aw_have = 1'b0;
        nxt_st.w_have = 1'b0;
        nxt_st.bvalid = 1'b1;
        nxt_st.bresp = brsdvs_pkg::RESP_OKAY;
        ph_idx = 6'(st_ff.awaddr[7:2]);
        if (st_ff.wstrb[0]) begin
          case (st_ff.awaddr)
            brsdvs_pkg::OFS_PG_MASK_A: nxt_st.mask_a = st_ff.wdata[6:0];
            brsdvs_pkg::OFS_PG_MASK_B: nxt_st.mask_b = st_ff.wdata[3:0];
            brsdvs_pkg::OFS_CTRL: nxt_st.ctrl = st_ff.wdata[7:0];
            brsdvs_pkg::OFS_PIN_MAP: nxt_st.pin_map = st_ff.wdata[7:0];
            brsdvs_pkg::OFS_ADC_SEL: nxt_st.adc_sel = st_ff.wdata[3:0];
            brsdvs_pkg::OFS_LDO: begin
              new_ldo_code = st_ff.wdata[5:0];
              new_ldo_en = st_ff.wdata[brsdvs_pkg::LDO_EN_BIT];
              nxt_st.ldo[brsdvs_pkg::LDO_EN_BIT] = new_ldo_en;
              // Range crossing only while off or in the disabling write
              if (!st_ff.ldo[brsdvs_pkg::LDO_EN_BIT] || !new_ldo_en ||
                  ((new_ldo_code >= brsdvs_pkg::LDO_UPPER_CODE) ==
                   (st_ff.ldo[5:0] >= brsdvs_pkg::LDO_UPPER_CODE))) begin
                nxt_st.ldo[5:0] = new_ldo_code;
              end
            end
            default: begin
            end
          endcase
        end
        if (st_ff.awaddr >= brsdvs_pkg::OFS_PRIMARY &&
            ph_idx < 6'h0b && st_ff.wstrb[0]) begin
          nxt_st.prim[3'(ph_idx - 6'h04)] = st_ff.wdata[7:0];
        end
        if (st_ff.awaddr >= brsdvs_pkg::OFS_ALTERNATE &&
            ph_idx < 6'h10) begin
          if (st_ff.wstrb[0]) begin
            nxt_st.alt[2'(ph_idx - 6'h0c)][7:0] = st_ff.wdata[7:0];
          end
          if (st_ff.wstrb[1]) begin
            nxt_st.alt[2'(ph_idx - 6'h0c)][brsdvs_pkg::ALT_SEL_BIT] =
              st_ff.wdata[brsdvs_pkg::ALT_SEL_BIT];
          end
        end
        if (!(st_ff.awaddr inside {brsdvs_pkg::OFS_PG_MASK_A,
            brsdvs_pkg::OFS_PG_MASK_B, brsdvs_pkg::OFS_CTRL,
            brsdvs_pkg::OFS_PIN_MAP, brsdvs_pkg::OFS_ADC_SEL,
            brsdvs_pkg::OFS_LDO, brsdvs_pkg::OFS_STATUS}) &&
            !(ph_idx >= 6'h04 && ph_idx < 6'h10)) begin
          nxt_st.bresp = brsdvs_pkg::RESP_SLVERR;
        end
      end
      // Read channel: one outstanding read
      if (st_ff.rvalid && I_RREADY) begin
        nxt_st.rvalid = 1'b0;
        nxt_st.arready = 1'b1;
      end
      if (I_ARVALID && st_ff.arready) begin
        nxt_st.arready = 1'b0;
        nxt_st.rvalid = 1'b1;
        nxt_st.rresp = brsdvs_pkg::RESP_OKAY;
        nxt_st.rdata = '0;
        ph_idx = 6'(I_ARADDR[7:2]);
        case (I_ARADDR)
          brsdvs_pkg::OFS_PG_MASK_A: nxt_st.rdata[6:0] = st_ff.mask_a;
          brsdvs_pkg::OFS_PG_MASK_B: nxt_st.rdata[3:0] = st_ff.mask_b;
          brsdvs_pkg::OFS_CTRL: nxt_st.rdata[7:0] = st_ff.ctrl;
          brsdvs_pkg::OFS_PIN_MAP: nxt_st.rdata[7:0] = st_ff.pin_map;
          brsdvs_pkg::OFS_ADC_SEL: nxt_st.rdata[3:0] = st_ff.adc_sel;
          brsdvs_pkg::OFS_LDO: nxt_st.rdata[6:0] = st_ff.ldo;
          brsdvs_pkg::OFS_STATUS: nxt_st.rdata[15:0] = {st_ff.triple_b,
            st_ff.triple_a, ramping, st_ff.pg_out, pg_ok, fault[4:0]};
          default: begin
            if (ph_idx >= 6'h04 && ph_idx < 6'h0b) begin
              nxt_st.rdata[7:0] = st_ff.prim[3'(ph_idx - 6'h04)];
            end else if (ph_idx >= 6'h0c && ph_idx < 6'h10) begin
              nxt_st.rdata[8:0] = st_ff.alt[2'(ph_idx - 6'h0c)];
            end else begin
              nxt_st.rresp = brsdvs_pkg::RESP_SLVERR;
            end
          end
        endcase
      end
      // Straps caught once after reset release, then held
      if (!st_ff.otp_done) begin
        nxt_st.otp_done = 1'b1;
        nxt_st.triple_a = otp_a;
        nxt_st.triple_b = otp_b;
      end
      nxt_st.pg_out = pg_ok ^ st_ff.mask_b[brsdvs_pkg::MB_POL_INV];
      nxt_st.pg_tag = st_ff.mask_b[brsdvs_pkg::MB_COMBINE] & pg_ok;
      // Index select keeps the measurement to a single rail
      nxt_st.ilmon = st_ff.adc_sel[3] ? 7'(7'h01 << st_ff.adc_sel[2:0])
        : 7'h00;
      nxt_st.rail_code = code_now;
      for (int i = 0; i < brsdvs_pkg::NUM_RAILS; i++) begin
        nxt_st.rail_en[i] = code_now[i] != 8'h00;
      end
      case (st_ff.ctrl[1:0])
        brsdvs_pkg::PH_FORCE_MULTI: nxt_st.phases_a = st_ff.triple_a ?
          2'h3 : 2'h2;
        brsdvs_pkg::PH_FORCE_SINGLE: nxt_st.phases_a = 2'h1;
        default: nxt_st.phases_a = light_a ? 2'h1
          : (st_ff.triple_a ? 2'h3 : 2'h2);
      endcase
      case (st_ff.ctrl[3:2])
        brsdvs_pkg::PH_FORCE_MULTI: nxt_st.phases_b = st_ff.triple_b ?
          2'h3 : 2'h2;
        brsdvs_pkg::PH_FORCE_SINGLE: nxt_st.phases_b = 2'h1;
        default: nxt_st.phases_b = light_b ? 2'h1
          : (st_ff.triple_b ? 2'h3 : 2'h2);
      endcase
      nxt_st.ana_en = |ana_req;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.mask_a <= brsdvs_pkg::RST_MASK_A;
      st_ff.mask_b <= brsdvs_pkg::RST_MASK_B;
      st_ff.ctrl <= brsdvs_pkg::RST_CTRL;
      st_ff.pin_map <= brsdvs_pkg::RST_PIN_MAP;
      st_ff.adc_sel <= brsdvs_pkg::RST_ADC_SEL;
      st_ff.ldo <= brsdvs_pkg::RST_LDO;
      st_ff.alt <= {brsdvs_pkg::NUM_DVS{brsdvs_pkg::RST_ALT}};
      st_ff.prim <= {brsdvs_pkg::NUM_RAILS{brsdvs_pkg::RST_CODE}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign O_AWREADY = st_ff.awready;
  assign O_WREADY = st_ff.wready;
  assign O_BVALID = st_ff.bvalid;
  assign O_BRESP = st_ff.bresp;
  assign O_ARREADY = st_ff.arready;
  assign O_RVALID = st_ff.rvalid;
  assign O_RRESP = st_ff.rresp;
  assign O_RDATA = st_ff.rdata;
  assign O_POWER_GOOD = st_ff.pg_out;
  assign O_RAIL_CODE = st_ff.rail_code;
  assign O_RAIL_EN = st_ff.rail_en;
  assign O_ADC_ILMON_SEL = st_ff.ilmon;
  assign O_ADC_PG_TAG = st_ff.pg_tag;
  assign O_PHASES_A = st_ff.phases_a;
  assign O_PHASES_B = st_ff.phases_b;
  assign O_STAGGER_120_A = st_ff.triple_a;
  assign O_STAGGER_120_B = st_ff.triple_b;
  assign O_LDO_EN = st_ff.ldo[brsdvs_pkg::LDO_EN_BIT];
  assign O_LDO_CODE = st_ff.ldo[5:0];
  assign O_ANA_LDO_EN = st_ff.ana_en;

endmodule // brsdvs_top

// ---- design/brsdvs_pkg.sv ----
package brsdvs_pkg;

  // ----------------------------------------------------------------------
  // Rail slots and sizes
  // ----------------------------------------------------------------------
  localparam int NUM_RAILS = 7;
  localparam int NUM_DVS = 4;
  localparam int NUM_SYNC = 25;
  localparam int NUM_ANA_REQ = 4;
  // Slot order: a_dual, b_dual, c_single, d_single, e_single, f_single,
  // g_single. Of these, the four a, b, d, f are the scaling rails.
  localparam int RAIL_A = 0;
  localparam int RAIL_B = 1;
  localparam int RAIL_C = 2;
  localparam int RAIL_D = 3;
  localparam int RAIL_E = 4;
  localparam int RAIL_F = 5;
  localparam int RAIL_G = 6;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PG_MASK_A = 8'h00;
  localparam logic [7:0] OFS_PG_MASK_B = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_PIN_MAP = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_ADC_SEL = 8'h44;
  localparam logic [7:0] OFS_LDO = 8'h48;
  localparam logic [7:0] OFS_PRIMARY = 8'h10;
  localparam logic [7:0] OFS_ALTERNATE = 8'h30;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int MB_EXT_MASK = 0;
  localparam int MB_TYPE_SEL = 1;
  localparam int MB_POL_INV = 2;
  localparam int MB_COMBINE = 3;
  localparam int ALT_SEL_BIT = 8;
  localparam int LDO_EN_BIT = 6;
  localparam logic [6:0] RST_MASK_A = 7'h7e;
  localparam logic [3:0] RST_MASK_B = 4'h1;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_MAP = 8'h00;
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [8:0] RST_ALT = 9'h000;
  localparam logic [3:0] RST_ADC_SEL = 4'h0;
  localparam logic [6:0] RST_LDO = 7'h00;
  localparam logic [5:0] LDO_UPPER_CODE = 6'h1b;

  // ----------------------------------------------------------------------
  // Phase force encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] PH_AUTO = 2'h0;
  localparam logic [1:0] PH_FORCE_MULTI = 2'h1;
  localparam logic [1:0] PH_FORCE_SINGLE = 2'h2;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CODE_STEP_UV = 10000;
  localparam int SLEW_UV_PER_US = 2500;
  localparam int DVS_STEP_NS = CODE_STEP_UV * 1000 / SLEW_UV_PER_US;
  localparam int DVS_STEP_CYC =
    (DVS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : brsdvs_pkg

// ---- design/brsdvs_sync.sv ----
module brsdvs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } brsdvs_sync_st_t;

  brsdvs_sync_st_t st_ff;
  brsdvs_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.meta = i_async;
      nxt_st.stab = st_ff.meta;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      // Flushes during reset
      st_ff <= '{i_async, st_ff.meta};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.stab;

endmodule // brsdvs_sync

// ---- design/brsdvs_slew.sv ----
module brsdvs_slew #(
  parameter int CODE_W = 8,
  parameter int STEP_CYC = 100
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic i_ce,
  input wire logic [CODE_W-1:0] i_target,
  output logic [CODE_W-1:0] o_code,
  output logic o_ramping
);

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [15:0] cnt;
  } brsdvs_slew_st_t;

  brsdvs_slew_st_t st_ff;
  brsdvs_slew_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      // Off and power-up jump; only live moves are rate limited
      if (i_target == '0 || st_ff.code == '0) begin
        nxt_st.code = i_target;
        nxt_st.cnt = '0;
      end else if (st_ff.code != i_target) begin
        if (st_ff.cnt == 16'(STEP_CYC - 1)) begin
          nxt_st.cnt = '0;
          if (st_ff.code < i_target) begin
            nxt_st.code = st_ff.code + CODE_W'(1);
          end else begin
            nxt_st.code = st_ff.code - CODE_W'(1);
          end
        end else begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end else begin
        nxt_st.cnt = '0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_code = st_ff.code;
  assign o_ramping = (st_ff.code != i_target) && (st_ff.code != '0)
    && (i_target != '0);

endmodule // brsdvs_slew

// ---- tb/brsdvs_rail_sense.sv ----
module brsdvs_rail_sense (
  input wire logic [6:0] i_rail_en,
  input wire logic [6:0] i_v_fault,
  input wire logic [6:0] i_i_fault,
  input wire logic i_ext_bad,
  output logic [6:0] o_vok,
  output logic [6:0] o_ilim,
  output logic o_ext_pg
);
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------------
  // Rail sense
  // -----------------------------------------------------------------------
  // An off rail has no output, so its window check fails too
  assign o_vok = i_rail_en & ~i_v_fault;
  assign o_ilim = i_i_fault;
  assign o_ext_pg = !i_ext_bad;
endmodule // brsdvs_rail_sense

// ---- tb/brsdvs_top_asserts.sv ----
module brsdvs_asserts (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [3:0] I_ANA_REQ,
  input wire logic [6:0] I_RAIL_ILIM,
  input wire logic [55:0] O_RAIL_CODE,
  input wire logic [6:0] O_RAIL_EN,
  input wire logic [1:0] O_PHASES_A,
  input wire logic O_ADC_PG_TAG,
  input wire logic O_STAGGER_120_A,
  input wire logic O_STAGGER_120_B,
  input wire logic O_ANA_LDO_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------------
  // Port relations
  // -----------------------------------------------------------------------
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  property p_en_a; O_RAIL_EN[0] == (O_RAIL_CODE[7:0] != 8'h00); endproperty
  a_en_a: assert property (p_en_a) else $error("rail a enable");
  property p_en_d; O_RAIL_EN[3] == (O_RAIL_CODE[31:24] != 8'h00); endproperty
  a_en_d: assert property (p_en_d) else $error("rail d enable");
  // Jumps only to or from zero; any other move is one code
  property p_slew;
    O_RAIL_CODE[7:0] != 8'h00 && $past(O_RAIL_CODE[7:0]) != 8'h00 |->
      8'(O_RAIL_CODE[7:0] - $past(O_RAIL_CODE[7:0]) + 8'h01) <= 8'h02;
  endproperty
  a_slew: assert property (p_slew) else $error("rail a slew");
  property p_trip_a; O_STAGGER_120_A |-> !O_RAIL_EN[2]; endproperty
  a_trip_a: assert property (p_trip_a) else $error("rail c on");
  property p_trip_b; O_STAGGER_120_B |-> !O_RAIL_EN[4]; endproperty
  a_trip_b: assert property (p_trip_b) else $error("rail e on");
  property p_stag; (O_PHASES_A == 2'h3) |-> O_STAGGER_120_A; endproperty
  a_stag: assert property (p_stag) else $error("triple not 120");
  property p_pg; I_RAIL_ILIM[0] [*4] |=> !O_ADC_PG_TAG; endproperty
  a_pg: assert property (p_pg) else $error("good despite limit");
  property p_ana; (|I_ANA_REQ) [*4] |=> O_ANA_LDO_EN; endproperty
  a_ana: assert property (p_ana) else $error("analog ldo off");
  c_ramp: cover property (O_RAIL_CODE[7:0] != $past(O_RAIL_CODE[7:0]));
  c_single: cover property (O_PHASES_A == 2'h1);
  c_tag: cover property (O_ADC_PG_TAG);
endmodule // brsdvs_asserts

bind brsdvs_top brsdvs_asserts u_brsdvs_asserts (.*);

// ---- tb/brsdvs_top_bench.sv ----
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module brsdvs_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  logic I_MCLK = '0, I_RST_N = '0, I_CE = '1, I_AWVALID = '0, I_WVALID = '0;
  logic I_BREADY = '0, I_ARVALID = '0, I_RREADY = '0, I_EXT_PG, eb = '0;
  logic I_SLEEP_CTRL_PIN_N = '0, I_AUX_ENABLE_PIN = '0, I_LIGHT_LOAD_A = '0;
  logic I_LIGHT_LOAD_B = '0, I_OTP_TRIPLE_A = '1, I_OTP_TRIPLE_B = '0;
  logic [7:0] I_AWADDR = '0, I_ARADDR = '0;
  logic [31:0] I_WDATA = '0, O_RDATA;
  logic [3:0] I_WSTRB = '1, I_ANA_REQ = '0;
  logic [6:0] I_RAIL_VOK, I_RAIL_ILIM, O_RAIL_EN, O_ADC_ILMON_SEL;
  logic [6:0] vf = '0, ifl = '0;
  logic [1:0] O_BRESP, O_RRESP, O_PHASES_A, O_PHASES_B;
  logic [55:0] O_RAIL_CODE;
  logic [5:0] O_LDO_CODE;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_POWER_GOOD;
  logic O_ADC_PG_TAG, O_STAGGER_120_A, O_STAGGER_120_B, O_LDO_EN, O_ANA_LDO_EN;
  int error_cnt = 0, compares = 0;
  brsdvs_top #(.STEP_CYC(STEP)) u_brsdvs_top (.*);
  brsdvs_rail_sense u_brsdvs_rail_sense (.i_rail_en(O_RAIL_EN),
    .i_v_fault(vf), .i_i_fault(ifl), .i_ext_bad(eb), .o_vok(I_RAIL_VOK),
    .o_ilim(I_RAIL_ILIM), .o_ext_pg(I_EXT_PG));
  initial forever #20 I_MCLK = ~I_MCLK;
  // -----------------------------------------------------------------------
  // Bus tasks
  // -----------------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge I_MCLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = brsdvs_pkg::RESP_OKAY);
    @(posedge I_MCLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= '1;
    I_WVALID <= '1;
    I_BREADY <= '1;
    // No response can come before both channels are taken
    do begin
      @(posedge I_MCLK);
      if (O_AWREADY) I_AWVALID <= '0;
      if (O_WREADY) I_WVALID <= '0;
    end while (O_BVALID !== 1'b1);
    I_BREADY <= '0;
    `CHK("bresp", r, O_BRESP)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = brsdvs_pkg::RESP_OKAY);
    @(posedge I_MCLK);
    I_ARADDR <= a;
    I_ARVALID <= '1;
    I_RREADY <= '1;
    do begin
      @(posedge I_MCLK);
      if (O_ARREADY) I_ARVALID <= '0;
    end while (O_RVALID !== 1'b1);
    I_RREADY <= '0;
    `CHK("rdata", e, O_RDATA)
    `CHK("rresp", r, O_RRESP)
  endtask
  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  task automatic t_regs();
    rd(8'h00, 32'(brsdvs_pkg::RST_MASK_A));
    rd(8'h04, 32'(brsdvs_pkg::RST_MASK_B));
    rd(8'h30, 32'h0);
    rd(8'h2c, 32'h0, brsdvs_pkg::RESP_SLVERR);
    wr(8'hfc, 32'h1, brsdvs_pkg::RESP_SLVERR);
  endtask
  task automatic t_pg();
    wr(8'h10, 32'h20);
    wr(8'h04, 32'h08);
    w(5);
    `CHK("pg", 1'b1, O_POWER_GOOD)
    `CHK("pg tag", 1'b1, O_ADC_PG_TAG)
    ifl <= 7'h01;
    w(5);
    `CHK("pg tag", 1'b0, O_ADC_PG_TAG)
    ifl <= '0;
    vf <= 7'h01;
    w(5);
    `CHK("pg", 1'b0, O_POWER_GOOD)
    wr(8'h04, 32'h0a);
    w(5);
    `CHK("pg", 1'b1, O_POWER_GOOD)
    wr(8'h00, 32'h7f);
    wr(8'h04, 32'h0c);
    eb <= '1;
    w(5);
    `CHK("pg", 1'b1, O_POWER_GOOD)
    wr(8'h04, 32'h08);
    wr(8'h00, 32'h7e);
    vf <= '0;
    eb <= '0;
  endtask
  task automatic t_dvs();
    wr(8'h10, 32'h24);
    vf <= 7'h01;
    w(6);
    `CHK("pg", 1'b1, O_POWER_GOOD)
    `CHK("rail a mid", 1'b1, O_RAIL_CODE[7:0] < 8'h24)
    w(4 * STEP + 8);
    `CHK("rail a", 8'h24, O_RAIL_CODE[7:0])
    `CHK("pg", 1'b0, O_POWER_GOOD)
    vf <= '0;
    wr(8'h28, 32'h10);
    w(100);
    wr(8'h28, 32'h11);
    w(1);
    `CHK("rail g", 8'h11, O_RAIL_CODE[55:48])
  endtask
  task automatic t_level();
    wr(8'h1c, 32'h40);
    wr(8'h38, 32'h100);
    w(2);
    `CHK("rail d on", 1'b0, O_RAIL_EN[3])
    wr(8'h0c, 32'h04);
    wr(8'h08, 32'h40);
    I_SLEEP_CTRL_PIN_N <= '1;
    w(5);
    `CHK("rail d", 8'h40, O_RAIL_CODE[31:24])
    I_SLEEP_CTRL_PIN_N <= '0;
    w(5);
    `CHK("rail d on", 1'b0, O_RAIL_EN[3])
  endtask
  task automatic t_phase();
    wr(8'h18, 32'h30);
    w(2);
    `CHK("rail c on", 1'b0, O_RAIL_EN[2])
    `CHK("stagger a", 1'b1, O_STAGGER_120_A)
    `CHK("stagger b", 1'b0, O_STAGGER_120_B)
    for (int i = 0; i < 4; i++) begin
      I_LIGHT_LOAD_A <= (i == 0);
      wr(8'h08, 32'(i));
      w(4);
      `CHK("phases", i[0] ? 2'h3 : 2'h1, O_PHASES_A)
      `CHK("phases b", 2'h2, O_PHASES_B)
    end
  endtask
  task automatic t_misc();
    wr(8'h48, 32'h50);
    wr(8'h48, 32'h60);
    w(1);
    `CHK("ldo", 6'h10, O_LDO_CODE)
    wr(8'h48, 32'h20);
    wr(8'h48, 32'h60);
    w(1);
    `CHK("ldo", 6'h20, O_LDO_CODE)
    `CHK("ldo en", 1'b1, O_LDO_EN)
    wr(8'h44, 32'h0b);
    I_ANA_REQ <= 4'h4;
    w(5);
    `CHK("ilmon", 7'h08, O_ADC_ILMON_SEL)
    `CHK("ana", 1'b1, O_ANA_LDO_EN)
    I_ANA_REQ <= '0;
    w(5);
    `CHK("ana", 1'b0, O_ANA_LDO_EN)
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    w(10);
    I_RST_N <= '1;
    t_regs();
    t_pg();
    t_dvs();
    t_level();
    t_phase();
    t_misc();
    stop_test();
  end
  initial begin
    w(5000);
    error_cnt++;
    stop_test();
  end
endmodule // brsdvs_top_bench
